// [rtl/oopa_defs.svh]
// Functional notes
// - Protection channel is row 4, columns 5 to 8, every frame, both signal kinds.
// - Protection channel bytes are time-shared among up to eight nested levels.
// - Single-slice mode: multiframe bits 6-8 pick path, tandem 1-6 or server level.
// - One protection channel instance only; multi-slice carries it in slice 1 only.
// - Multi-slice protection bytes pass through untouched as a coordination channel.
// - Experimental bytes sit at row 2 columns 4, 14 and row 3 columns 13, 14.
// - One experimental set in single-slice mode, one per slice in multi-slice mode.
// - Experimental bytes may be overwritten at a domain boundary.
// - Zero row 2 columns 1-2, row 4 columns 9-14 and row 2 column 3 bit 8.
// - Slice 1 as above; later slices zero row 2 col 1-3, row 4 col 5-14.
// - One identifier byte per frame at row 4, column 15.
// - Identifier byte i is the one seen when the multiframe counter equals i.
// - Identifier byte 0 is the payload kind; experimental and proprietary kinds flagged.
// - One identifier sequence per slice, each stored independently.
// - Payload kind code points such as asynchronous and framing-procedure mappings decoded.
`ifndef OOPA_DEFS_SVH
`define OOPA_DEFS_SVH
`define OOPA_ROW_APS        3'h4
`define OOPA_COL_APS_FIRST  4'h5
`define OOPA_COL_APS_LAST   4'h8
`define OOPA_ROW_EXP_A      3'h2
`define OOPA_COL_EXP_A0     4'h4
`define OOPA_COL_EXP_A1     4'hE
`define OOPA_ROW_EXP_B      3'h3
`define OOPA_COL_EXP_B0     4'hD
`define OOPA_COL_EXP_B1     4'hE
`define OOPA_ROW_RES_A      3'h2
`define OOPA_COL_RES_A_LAST 4'h2
`define OOPA_COL_RES_BIT    4'h3
`define OOPA_RES_BIT_MASK   8'hFE
`define OOPA_ROW_RES_B      3'h4
`define OOPA_COL_RES_B_LO   4'h9
`define OOPA_COL_RES_B_HI   4'hE
`define OOPA_ROW_PSI        3'h4
`define OOPA_COL_PSI        4'hF
`define OOPA_FIRST_SLICE    8'h01
`define OOPA_PK_EXPERIMENT  8'h01
`define OOPA_PK_ASYNC_CBR   8'h02
`define OOPA_PK_GFP         8'h05
`define OOPA_PK_PROP_LO     8'h80
`define OOPA_PK_PROP_HI     8'h8F
`define OOPA_LEVEL_PATH     3'h0
`define OOPA_LEVEL_SERVER   3'h7
`endif

// [rtl/oopa_pkg.sv]
package oopa_pkg;
    // One overhead byte on the stream with its frame position.
    typedef struct packed {
        logic       valid;
        logic [2:0] row;
        logic [3:0] col;
        logic [7:0] slice;
        logic [7:0] multiframe_counter_byte;
        logic [7:0] data;
    } oopa_beat_t;

    typedef struct packed {
        logic       experimental;
        logic       proprietary;
        logic       async_cbr;
        logic       gfp;
    } oopa_kind_flags_t;
endpackage : oopa_pkg

// [rtl/oopa_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "oopa_defs.svh"
module oopa_top #(
    parameter int MAX_SLICES = 1
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic                     multi_slice,
    input  wire oopa_pkg::oopa_beat_t     rx_beat,
    input  wire oopa_pkg::oopa_beat_t     tx_in,
    input  wire logic                     aps_ins_en,
    input  wire logic [31:0]              aps_ins_data,
    input  wire logic                     exp_clear_en,
    input  wire logic                     psi_ins_en,
    input  wire logic [7:0]               psi_ins_byte,
    input  wire logic [7:0]               psi_rd_slice,
    input  wire logic [7:0]               psi_rd_index,
    output oopa_pkg::oopa_beat_t          tx_out,
    output logic [7:0][31:0]              aps_level,
    output logic                          aps_update,
    output logic [2:0]                    aps_update_level,
    output logic [7:0]                    psi_rd_data,
    output logic [7:0]                    payload_kind,
    output oopa_pkg::oopa_kind_flags_t    kind_flags,
    output logic [7:0]                    exp_byte,
    output logic                          exp_update
);

    // ------------------------------------------------------------------
    // Position decode
    // ------------------------------------------------------------------
    // Single-slice signals have no slice numbering, so they count as slice 1.
    logic rx_first;
    logic tx_first;
    assign rx_first = !multi_slice || (rx_beat.slice == `OOPA_FIRST_SLICE);
    assign tx_first = !multi_slice || (tx_in.slice == `OOPA_FIRST_SLICE);

    logic rx_in_aps;
    logic tx_in_aps;
    assign rx_in_aps = rx_beat.valid && rx_first && (rx_beat.row == `OOPA_ROW_APS) &&
                       (rx_beat.col >= `OOPA_COL_APS_FIRST) && (rx_beat.col <= `OOPA_COL_APS_LAST);
    assign tx_in_aps = tx_first && (tx_in.row == `OOPA_ROW_APS) &&
                       (tx_in.col >= `OOPA_COL_APS_FIRST) && (tx_in.col <= `OOPA_COL_APS_LAST);

    // Every slice carries an experimental set; all slices capture into the one shared exp_byte.
    function automatic logic oopa_is_exp(input logic [2:0] row, input logic [3:0] col);
        oopa_is_exp = ((row == `OOPA_ROW_EXP_A) && ((col == `OOPA_COL_EXP_A0) || (col == `OOPA_COL_EXP_A1))) ||
                      ((row == `OOPA_ROW_EXP_B) && ((col == `OOPA_COL_EXP_B0) || (col == `OOPA_COL_EXP_B1)));
    endfunction : oopa_is_exp

    logic rx_in_exp;
    logic tx_in_exp;
    assign rx_in_exp = rx_beat.valid && oopa_is_exp(rx_beat.row, rx_beat.col);
    assign tx_in_exp = oopa_is_exp(tx_in.row, tx_in.col);

    logic rx_in_psi;
    logic tx_in_psi;
    assign rx_in_psi = rx_beat.valid && (rx_beat.row == `OOPA_ROW_PSI) && (rx_beat.col == `OOPA_COL_PSI);
    assign tx_in_psi = (tx_in.row == `OOPA_ROW_PSI) && (tx_in.col == `OOPA_COL_PSI);

    // Reserved overhead in the transmit stream.
    logic tx_res_full;
    logic tx_res_bit;
    always_comb begin
        tx_res_full = 1'b0;
        tx_res_bit  = 1'b0;
        if (tx_in.row == `OOPA_ROW_RES_A) begin
            if (tx_in.col != 4'h0 && tx_in.col <= `OOPA_COL_RES_A_LAST) begin
                tx_res_full = 1'b1;
            end
            if (tx_in.col == `OOPA_COL_RES_BIT) begin
                if (tx_first) begin
                    tx_res_bit = 1'b1;
                end else begin
                    tx_res_full = 1'b1;
                end
            end
        end
        if (tx_in.row == `OOPA_ROW_RES_B) begin
            if (tx_in.col >= `OOPA_COL_RES_B_LO && tx_in.col <= `OOPA_COL_RES_B_HI) begin
                tx_res_full = 1'b1;
            end
            if (!tx_first && tx_in.col >= `OOPA_COL_APS_FIRST && tx_in.col <= `OOPA_COL_APS_LAST) begin
                tx_res_full = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit insertion
    // ------------------------------------------------------------------
    // Insertion adds one cycle of latency to every beat, overhead or not.
    oopa_pkg::oopa_beat_t next_tx_out;
    logic [1:0]           tx_aps_sel;
    assign tx_aps_sel = 2'(tx_in.col - `OOPA_COL_APS_FIRST);

    always_comb begin
        next_tx_out = tx_in;
        if (tx_in.valid) begin
            if (tx_res_full) begin
                next_tx_out.data = 8'h00;
            end else if (tx_res_bit) begin
                next_tx_out.data = tx_in.data & `OOPA_RES_BIT_MASK;
            end else if (tx_in_aps && aps_ins_en && !multi_slice) begin
                // The caller supplies the word for the level that owns this frame.
                next_tx_out.data = aps_ins_data[8'(31 - 8 * int'(tx_aps_sel)) -: 8];
            end else if (tx_in_exp && exp_clear_en) begin
                next_tx_out.data = 8'h00;
            end else if (tx_in_psi && psi_ins_en) begin
                next_tx_out.data = psi_ins_byte;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_out <= '0;
        end else begin
            tx_out <= next_tx_out;
        end
    end

    // ------------------------------------------------------------------
    // Protection channel extraction
    // ------------------------------------------------------------------
    // In multi-slice mode the bytes are stored unchanged under the path level.
    logic [23:0]      aps_shift;
    logic [23:0]      next_aps_shift;
    logic [7:0][31:0] next_aps_level;
    logic             next_aps_update;
    logic [2:0]       next_aps_update_level;
    logic [2:0]       rx_level;

    assign rx_level = multi_slice ? `OOPA_LEVEL_PATH : rx_beat.multiframe_counter_byte[2:0];

    always_comb begin
        next_aps_shift        = aps_shift;
        next_aps_level        = aps_level;
        next_aps_update       = 1'b0;
        next_aps_update_level = aps_update_level;
        if (rx_in_aps) begin
            if (rx_beat.col == `OOPA_COL_APS_LAST) begin
                next_aps_level[rx_level] = {aps_shift, rx_beat.data};
                next_aps_update          = 1'b1;
                next_aps_update_level    = rx_level;
            end else begin
                next_aps_shift = {aps_shift[15:0], rx_beat.data};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aps_shift        <= '0;
            aps_level        <= '0;
            aps_update       <= 1'b0;
            aps_update_level <= '0;
        end else begin
            aps_shift        <= next_aps_shift;
            aps_level        <= next_aps_level;
            aps_update       <= next_aps_update;
            aps_update_level <= next_aps_update_level;
        end
    end

    // ------------------------------------------------------------------
    // Experimental overhead capture
    // ------------------------------------------------------------------
    logic [7:0] next_exp_byte;
    logic       next_exp_update;

    always_comb begin
        next_exp_byte   = exp_byte;
        next_exp_update = 1'b0;
        if (rx_in_exp) begin
            next_exp_byte   = rx_beat.data;
            next_exp_update = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            exp_byte   <= '0;
            exp_update <= 1'b0;
        end else begin
            exp_byte   <= next_exp_byte;
            exp_update <= next_exp_update;
        end
    end

    // ------------------------------------------------------------------
    // Payload structure identifier
    // ------------------------------------------------------------------
    // Slices beyond MAX_SLICES are dropped rather than aliased onto stored ones.
    localparam int PSI_DEPTH = MAX_SLICES * 256;
    localparam int PSI_AW    = $clog2(PSI_DEPTH);

    logic [7:0]        psi_mem [PSI_DEPTH];
    logic [PSI_AW-1:0] psi_wr_addr;
    logic [PSI_AW-1:0] psi_rd_addr;
    logic              psi_wr_ok;
    logic              psi_rd_ok;
    logic [7:0]        rx_slice_idx;
    logic [7:0]        rd_slice_idx;

    assign rx_slice_idx = multi_slice ? 8'(rx_beat.slice - `OOPA_FIRST_SLICE) : 8'h00;
    assign rd_slice_idx = 8'(psi_rd_slice - `OOPA_FIRST_SLICE);
    assign psi_wr_ok    = rx_in_psi && (rx_beat.slice >= `OOPA_FIRST_SLICE || !multi_slice) &&
                          (int'(rx_slice_idx) < MAX_SLICES);
    assign psi_rd_ok    = (psi_rd_slice >= `OOPA_FIRST_SLICE) && (int'(rd_slice_idx) < MAX_SLICES);
    assign psi_wr_addr  = PSI_AW'({rx_slice_idx, rx_beat.multiframe_counter_byte});
    assign psi_rd_addr  = PSI_AW'({rd_slice_idx, psi_rd_index});

    always_ff @(posedge ref_clk) begin
        if (psi_wr_ok) begin
            psi_mem[psi_wr_addr] <= rx_beat.data;
        end
    end

    logic [7:0]                 next_psi_rd_data;
    logic [7:0]                 next_payload_kind;
    oopa_pkg::oopa_kind_flags_t next_kind_flags;

    always_comb begin
        next_psi_rd_data  = psi_rd_ok ? psi_mem[psi_rd_addr] : 8'h00;
        next_payload_kind = payload_kind;
        if (rx_in_psi && rx_first && rx_beat.multiframe_counter_byte == 8'h00) begin
            next_payload_kind = rx_beat.data;
        end
        next_kind_flags.experimental = (next_payload_kind == `OOPA_PK_EXPERIMENT);
        next_kind_flags.proprietary  = (next_payload_kind >= `OOPA_PK_PROP_LO) &&
                                       (next_payload_kind <= `OOPA_PK_PROP_HI);
        next_kind_flags.async_cbr    = (next_payload_kind == `OOPA_PK_ASYNC_CBR);
        next_kind_flags.gfp          = (next_payload_kind == `OOPA_PK_GFP);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            psi_rd_data  <= '0;
            payload_kind <= '0;
            kind_flags   <= '0;
        end else begin
            psi_rd_data  <= next_psi_rd_data;
            payload_kind <= next_payload_kind;
            kind_flags   <= next_kind_flags;
        end
    end

endmodule : oopa_top
`default_nettype wire

// [tb/oopa_top_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module oopa_top_monitor #(
    parameter int MAX_SLICES = 1
) (
    input wire logic                       ref_clk,
    input wire logic                       rst_n,
    input wire logic                       multi_slice,
    input wire oopa_pkg::oopa_beat_t       rx_beat,
    input wire oopa_pkg::oopa_beat_t       tx_in,
    input wire logic                       aps_ins_en,
    input wire logic [31:0]                aps_ins_data,
    input wire oopa_pkg::oopa_beat_t       tx_out,
    input wire logic                       aps_update,
    input wire logic [2:0]                 aps_update_level,
    input wire logic [7:0]                 payload_kind,
    input wire oopa_pkg::oopa_kind_flags_t kind_flags,
    input wire logic [7:0]                 exp_byte,
    input wire logic                       exp_update
);
    // ------------------
    // Overhead checks
    // ------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic tx_r2 = tx_in.valid && tx_in.row == 3'h2;
    wire logic tx_r4 = tx_in.valid && tx_in.row == 3'h4;
    wire logic tx_s1 = !multi_slice || tx_in.slice == 8'h01;
    wire logic rx_s1 = rx_beat.valid && (!multi_slice || rx_beat.slice == 8'h01);
    sequence s_aps_last;
        rx_s1 && !multi_slice && rx_beat.row == 3'h4 && rx_beat.col == 4'h8;
    endsequence
    sequence s_aps_word;
        aps_update && aps_update_level == $past(rx_beat.multiframe_counter_byte[2:0]);
    endsequence
    AST_APS_CAPTURE: assert property (s_aps_last |=> s_aps_word)
        else $error("protection word level wrong");
    AST_RES_ROW2: assert property (tx_r2 && tx_in.col inside {4'h1, 4'h2} |=> tx_out.data == 8'h00)
        else $error("row 2 reserved byte not zero");
    AST_RES_ROW4: assert property (tx_r4 && tx_in.col inside {[4'h9:4'hE]} |=> tx_out.data == 8'h00)
        else $error("row 4 reserved byte not zero");
    AST_RES_BIT: assert property (tx_r2 && tx_in.col == 4'h3 && tx_s1 |=> !tx_out.data[0])
        else $error("reserved bit not zero");
    AST_RES_SLICE: assert property (tx_r4 && !tx_s1 && tx_in.col inside {[4'h5:4'h8]} |=> tx_out.data == 8'h00)
        else $error("later slice protection byte not zero");
    AST_RES_SLICE_R2: assert property (tx_r2 && !tx_s1 && tx_in.col == 4'h3 |=> tx_out.data == 8'h00)
        else $error("later slice row 2 byte not zero");
    AST_APS_INSERT: assert property (tx_r4 && tx_in.col == 4'h5 && aps_ins_en && !multi_slice
        |=> tx_out.data == $past(aps_ins_data[31:24]))
        else $error("protection insert wrong");
    AST_KIND_CAPTURE: assert property (rx_s1 && rx_beat.row == 3'h4 && rx_beat.col == 4'hF
        && rx_beat.multiframe_counter_byte == 8'h00 |=> payload_kind == $past(rx_beat.data))
        else $error("payload kind not captured");
    AST_KIND_FLAGS: assert property (kind_flags == {payload_kind == 8'h01,
        payload_kind inside {[8'h80:8'h8F]}, payload_kind == 8'h02, payload_kind == 8'h05})
        else $error("kind flags disagree");
    AST_EXP_CAPTURE: assert property (rx_beat.valid &&
        ((rx_beat.row == 3'h2 && rx_beat.col inside {4'h4, 4'hE})
        || (rx_beat.row == 3'h3 && rx_beat.col inside {4'hD, 4'hE}))
        |=> exp_update && exp_byte == $past(rx_beat.data))
        else $error("experimental byte not captured");
endmodule : oopa_top_monitor
bind oopa_top oopa_top_monitor #(.MAX_SLICES(MAX_SLICES)) u_monitor (
    .ref_clk(ref_clk), .rst_n(rst_n), .multi_slice(multi_slice), .rx_beat(rx_beat), .tx_in(tx_in),
    .aps_ins_en(aps_ins_en), .aps_ins_data(aps_ins_data), .tx_out(tx_out), .aps_update(aps_update),
    .aps_update_level(aps_update_level), .payload_kind(payload_kind), .kind_flags(kind_flags),
    .exp_byte(exp_byte), .exp_update(exp_update));
`default_nettype wire

// [tb/oopa_peer.sv]
`timescale 1ns/10ps
`default_nettype none
module oopa_peer (
    input  wire logic           ref_clk,
    output oopa_pkg::oopa_beat_t rx_beat
);
    // ------------------
    // Peer framer
    // ------------------
    initial rx_beat = '0;
    // Idle beats clear valid and invert all other fields so a stale byte can never pass for a fresh capture.
    task automatic send(input logic [2:0] row, input logic [3:0] col, input logic [7:0] slice,
                        input logic [7:0] multiframe_counter_byte, input logic [7:0] data, input int gap);
        @(posedge ref_clk);
        #1 rx_beat = {1'b1, row, col, slice, multiframe_counter_byte, data};
        @(posedge ref_clk);
        #1 rx_beat = {1'b0, ~rx_beat[30:0]};
        repeat (gap) begin
            @(posedge ref_clk);
            #1 rx_beat = {1'b0, ~rx_beat[30:0]};
        end
    endtask : send
endmodule : oopa_peer
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic ref_clk, rst_n, multi_slice, aps_ins_en, exp_clear_en, psi_ins_en, pending;
    logic aps_update, exp_update;
    logic [31:0] aps_ins_data, lfsr, r;
    logic [7:0] psi_ins_byte, psi_rd_slice, psi_rd_index, psi_rd_data, payload_kind, exp_byte;
    logic [7:0][31:0] aps_level, want;
    logic [2:0] aps_update_level;
    oopa_pkg::oopa_beat_t rx_beat, tx_in, tx_out, exp_prev;
    oopa_pkg::oopa_beat_t exp_q[$];
    oopa_pkg::oopa_kind_flags_t kind_flags;
    logic [7:0] kinds [6] = '{8'h01, 8'h02, 8'h05, 8'h80, 8'h8F, 8'h03};
    logic [6:0] exp_pos [4] = '{7'h24, 7'h2E, 7'h3D, 7'h3E};
    int errors, check_count, cycles;
    // ------------------
    // Harness
    // ------------------
    oopa_top #(.MAX_SLICES(2)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .multi_slice(multi_slice), .rx_beat(rx_beat), .tx_in(tx_in),
        .aps_ins_en(aps_ins_en), .aps_ins_data(aps_ins_data), .exp_clear_en(exp_clear_en),
        .psi_ins_en(psi_ins_en), .psi_ins_byte(psi_ins_byte), .psi_rd_slice(psi_rd_slice),
        .psi_rd_index(psi_rd_index), .tx_out(tx_out), .aps_level(aps_level), .aps_update(aps_update),
        .aps_update_level(aps_update_level), .psi_rd_data(psi_rd_data), .payload_kind(payload_kind),
        .kind_flags(kind_flags), .exp_byte(exp_byte), .exp_update(exp_update));
    oopa_peer u_peer (.ref_clk(ref_clk), .rx_beat(rx_beat));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] rnd();
        lfsr = lfsr[0] ? (lfsr >> 1) ^ 32'hA3000000 : lfsr >> 1;
        return lfsr;
    endfunction : rnd
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want_v);
        check_count++;
        if (seen !== want_v) begin
            errors++;
            $display("Error %s expected %0h seen %0h", name, want_v, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("Checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict
    function automatic oopa_pkg::oopa_beat_t model(input oopa_pkg::oopa_beat_t b);
        logic s1;
        s1 = !multi_slice || b.slice == 8'h01;
        if (!b.valid) return b;
        if ((b.row == 3'h2 && (b.col inside {4'h1, 4'h2} || (!s1 && b.col == 4'h3))) ||
            (b.row == 3'h4 && (b.col inside {[4'h9:4'hE]} || (!s1 && b.col inside {[4'h5:4'h8]}))))
            b.data = 8'h00;
        else if (b.row == 3'h2 && b.col == 4'h3) b.data[0] = 1'b0;
        else if (b.row == 3'h4 && b.col inside {[4'h5:4'h8]} && aps_ins_en && !multi_slice)
            b.data = aps_ins_data[8 * (8 - b.col) +: 8];
        else if (exp_clear_en && ((b.row == 3'h2 && b.col inside {4'h4, 4'hE}) ||
                 (b.row == 3'h3 && b.col inside {4'hD, 4'hE}))) b.data = 8'h00;
        else if (psi_ins_en && b.row == 3'h4 && b.col == 4'hF) b.data = psi_ins_byte;
        return b;
    endfunction : model
    task automatic tx_rand(input logic ms);
        @(posedge ref_clk);
        #1 r = rnd();
        if (pending) exp_q.push_back(exp_prev);
        multi_slice = ms;
        {aps_ins_en, exp_clear_en, psi_ins_en} = r[2:0];
        psi_ins_byte = r[15:8];
        aps_ins_data = rnd();
        r = rnd();
        tx_in = {r[3] | r[4], 3'(r[6:5]) + 3'h1, r[11:8] == 4'h0 ? 4'hF : r[11:8],
                 r[12] ? 8'h02 : 8'h01, r[23:16], r[31:24]};
        exp_prev = model(tx_in);
        pending = 1'b1;
    endtask : tx_rand
    task automatic rd(input logic [7:0] slice, input logic [7:0] idx, input logic [7:0] v);
        @(posedge ref_clk);
        #1 {psi_rd_slice, psi_rd_index} = {slice, idx};
        repeat (2) @(posedge ref_clk);
        #2 check("psi_rd_data", psi_rd_data, v);
    endtask : rd
    always @(posedge ref_clk) begin
        #2;
        if (exp_q.size() > 0) check("tx_out", tx_out, exp_q.pop_front());
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        lfsr = 32'h126DB2A7;
        {errors, check_count, cycles} = '0;
        {rst_n, pending, multi_slice, aps_ins_en, exp_clear_en, psi_ins_en} = '0;
        {tx_in, aps_ins_data, psi_ins_byte, psi_rd_slice, psi_rd_index} = '0;
        repeat (20) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        repeat (400) tx_rand(1'b0);
        repeat (400) tx_rand(1'b1);
        @(posedge ref_clk);
        #1 exp_q.push_back(exp_prev);
        {pending, multi_slice} = '0;
        for (int l = 0; l < 8; l++) begin
            want[l] = rnd();
            for (int c = 5; c < 9; c++)
                u_peer.send(3'h4, 4'(c), 8'h01, {lfsr[7:3], 3'(l)}, want[l][8 * (8 - c) +: 8], c == 6 ? 3 : 0);
        end
        repeat (3) @(posedge ref_clk);
        #2 for (int l = 0; l < 8; l++) check("aps_level", aps_level[l], want[l]);
        @(posedge ref_clk);
        #1 multi_slice = 1'b1;
        for (int c = 5; c < 9; c++) u_peer.send(3'h4, 4'(c), 8'h02, 8'h03, 8'hEE, 0);
        for (int c = 5; c < 9; c++) u_peer.send(3'h4, 4'(c), 8'h01, 8'h05, 8'(c), 0);
        repeat (3) @(posedge ref_clk);
        #2 check("aps_slice1", aps_level[0], 32'h05060708);
        check("aps_level5", aps_level[5], want[5]);
        u_peer.send(3'h4, 4'hF, 8'h02, 8'h07, 8'hA5, 0);
        u_peer.send(3'h4, 4'hF, 8'h01, 8'h07, 8'h5A, 0);
        u_peer.send(3'h4, 4'hF, 8'h03, 8'h07, 8'h33, 0);
        rd(8'h02, 8'h07, 8'hA5);
        rd(8'h01, 8'h07, 8'h5A);
        rd(8'h03, 8'h07, 8'h00);
        @(posedge ref_clk);
        #1 multi_slice = 1'b0;
        foreach (kinds[i]) begin
            u_peer.send(3'h4, 4'hF, 8'h01, 8'h00, kinds[i], 1);
            check("payload_kind", payload_kind, kinds[i]);
            check("kind_flags", kind_flags, {kinds[i] == 8'h01, kinds[i] inside {[8'h80:8'h8F]},
                  kinds[i] == 8'h02, kinds[i] == 8'h05});
        end
        u_peer.send(3'h4, 4'hF, 8'h01, 8'h01, 8'h77, 1);
        check("kind_hold", payload_kind, 8'h03);
        rd(8'h01, 8'h01, 8'h77);
        rd(8'h01, 8'h00, 8'h03);
        foreach (exp_pos[i]) begin
            u_peer.send(exp_pos[i][6:4], exp_pos[i][3:0], 8'h01, 8'h00, 8'(i) ^ 8'hC3, 0);
            check("exp_byte", exp_byte, 8'(i) ^ 8'hC3);
        end
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
